// ==== logic/sram_port_pkg.sv ====
package sram_port_pkg;

  // words moved per accepted address
  localparam int unsigned BURST_WORDS = 2;
  // narrowest organisation whose burst counter loads the address lsb
  localparam int unsigned WIDE_DW_MIN = 18;
  // entries in the read data buffer
  localparam int unsigned BUF_DEPTH   = 2;
  // synchroniser depth for every pin
  localparam int unsigned SYNC_STAGES = 2;
  // reset values
  localparam logic        OE_N_RST    = 1'b1;
  localparam logic        BURST_RST   = 1'b0;

  // command sequencer, gray along idle -> write low -> write high
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WR_LO  = 2'b01,
    ST_WR_HI  = 2'b11,
    ST_RD_GAP = 2'b10
  } seq_state_e;

endpackage

// ==== logic/ddr2_burst2_sram_port.sv ====
module ddr2_burst2_sram_port #(
  parameter int unsigned DW = 18,
  parameter int unsigned AW = 8
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  input  wire logic          i_ce,
  input  wire logic          i_k,
  input  wire logic          i_k_n,
  input  wire logic          i_c,
  input  wire logic          i_c_n,
  input  wire logic          i_single_clk,
  input  wire logic          i_load_strobe_n,
  input  wire logic          i_rw,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_dq,
  output logic      [DW-1:0] o_dq,
  output logic               o_dq_oe_n,
  output logic               o_echo_clk,
  output logic               o_echo_clk_n
);

  localparam int unsigned SW    = 7 + AW + DW;
  localparam int unsigned DEPTH = 2 ** (AW + 1);
  localparam bit          WIDE  = (DW >= sram_port_pkg::WIDE_DW_MIN);

  // organisations served: x8, x9, x18, x36
  if (!(DW == 8 || DW == 9 || DW == 18 || DW == 36) || AW < 2 || AW > 20) begin : g_bad_param
    $error("unsupported data or address width");
  end

  //////////////////////////////////////////////////////////////////////////////
  // array index from address and burst bit
  function automatic logic [AW:0] word_idx(input logic [AW-1:0] a, input logic b);
    logic [AW:0] r;
    r = '0;
    if (WIDE) begin
      r = {1'b0, a[AW-1:1], b};
    end else begin
      r = {a, b};
    end
    return r;
  endfunction

  // rising edge of a sampled level
  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  logic [SW-1:0] sy1_r;
  logic [SW-1:0] sy1_nxt;
  logic [SW-1:0] sy2_r;
  logic [SW-1:0] sy2_nxt;
  logic [3:0]    clk_d_r;
  logic [3:0]    clk_d_nxt;

  always_comb begin
    sy1_nxt   = {i_k, i_k_n, i_c, i_c_n, i_single_clk, i_load_strobe_n, i_rw, i_addr, i_dq};
    sy2_nxt   = sy1_r;
    clk_d_nxt = sy2_r[SW-1 -: 4];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sy1_r   <= '0;
      sy2_r   <= '0;
      clk_d_r <= '0;
    end else if (i_ce) begin
      sy1_r   <= sy1_nxt;
      sy2_r   <= sy2_nxt;
      clk_d_r <= clk_d_nxt;
    end
  end

  // synchronised fields
  logic          k_s;
  logic          kn_s;
  logic          c_s;
  logic          cn_s;
  logic          single_s;
  logic          ld_n_s;
  logic          rw_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] dq_s;
  logic          k_rise;
  logic          kn_rise;
  logic          out_t_rise;
  logic          out_c_rise;
  logic          out_t_lvl;
  logic          out_c_lvl;

  // only rising edges are ever detected; a 160 ns link clock gives many core cycles per half
  always_comb begin
    {k_s, kn_s, c_s, cn_s, single_s, ld_n_s, rw_s, addr_s, dq_s} = sy2_r;
    k_rise     = rise(k_s, clk_d_r[3]);
    kn_rise    = rise(kn_s, clk_d_r[2]);
    // single clock domain: the input pair stands in for the output pair
    out_t_rise = single_s ? k_rise : rise(c_s, clk_d_r[1]);
    out_c_rise = single_s ? kn_rise : rise(cn_s, clk_d_r[0]);
    out_t_lvl  = single_s ? k_s : c_s;
    out_c_lvl  = single_s ? kn_s : cn_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // array
  logic [DW-1:0] mem [DEPTH];
  logic          mem_we;
  logic [AW:0]   mem_widx;
  logic [DW-1:0] mem_wdata;

  //////////////////////////////////////////////////////////////////////////////
  // two-entry read buffer
  logic [DW-1:0] buf_q_r [sram_port_pkg::BUF_DEPTH];
  logic [DW-1:0] buf_q_nxt [sram_port_pkg::BUF_DEPTH];
  logic          buf_wp_r;
  logic          buf_wp_nxt;
  logic          buf_rp_r;
  logic          buf_rp_nxt;
  logic [1:0]    buf_cnt_r;
  logic [1:0]    buf_cnt_nxt;
  logic          push_valid;
  logic          push_ready;
  logic [DW-1:0] push_data;
  logic          pop_valid;
  logic          pop_ready;

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer and burst counter
  sram_port_pkg::seq_state_e st_r;
  sram_port_pkg::seq_state_e st_nxt;
  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic          burst_r;
  logic          burst_nxt;
  logic          rd_act_r;
  logic          rd_act_nxt;
  logic          rd_second_r;
  logic          rd_second_nxt;
  logic          accept;

  // a read drains the array into the buffer in core cycles, stalled by a full buffer
  always_comb begin
    st_nxt        = st_r;
    addr_nxt      = addr_r;
    burst_nxt     = burst_r;
    rd_act_nxt    = rd_act_r;
    rd_second_nxt = rd_second_r;
    mem_we        = 1'b0;
    mem_widx      = word_idx(addr_r, burst_r);
    mem_wdata     = dq_s;
    push_valid    = rd_act_r;
    push_data     = mem[word_idx(addr_r, burst_r)];
    // strobe and select are sampled with the address on the same edge
    accept        = k_rise & ~ld_n_s & ~rd_act_r;
    case (st_r)
      sram_port_pkg::ST_IDLE: begin
        if (accept) begin
          addr_nxt  = addr_s;
          burst_nxt = WIDE ? addr_s[0] : sram_port_pkg::BURST_RST;
          if (rw_s) begin
            rd_act_nxt    = 1'b1;
            rd_second_nxt = 1'b0;
            st_nxt        = sram_port_pkg::ST_RD_GAP;
          end else begin
            st_nxt = sram_port_pkg::ST_WR_LO;
          end
        end
      end
      sram_port_pkg::ST_WR_LO: begin
        // the skipped address edge carries the first write word
        if (k_rise) begin
          mem_we    = 1'b1;
          burst_nxt = ~burst_r;
          st_nxt    = sram_port_pkg::ST_WR_HI;
        end
      end
      sram_port_pkg::ST_WR_HI: begin
        if (kn_rise) begin
          mem_we    = 1'b1;
          burst_nxt = ~burst_r;
          st_nxt    = sram_port_pkg::ST_IDLE;
        end
      end
      sram_port_pkg::ST_RD_GAP: begin
        if (k_rise) begin
          st_nxt = sram_port_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = sram_port_pkg::ST_IDLE;
      end
    endcase
    if (rd_act_r && push_ready) begin
      burst_nxt     = ~burst_r;
      rd_second_nxt = 1'b1;
      if (rd_second_r) begin
        rd_act_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_r        <= sram_port_pkg::ST_IDLE;
      addr_r      <= '0;
      burst_r     <= sram_port_pkg::BURST_RST;
      rd_act_r    <= 1'b0;
      rd_second_r <= 1'b0;
    end else if (i_ce) begin
      st_r        <= st_nxt;
      addr_r      <= addr_nxt;
      burst_r     <= burst_nxt;
      rd_act_r    <= rd_act_nxt;
      rd_second_r <= rd_second_nxt;
    end
  end

  // array storage holds no reset; contents are undefined until written
  always_ff @(posedge i_core_clk) begin
    if (i_ce && mem_we) begin
      mem[mem_widx] <= mem_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffer pointers and storage
  always_comb begin
    buf_q_nxt   = buf_q_r;
    buf_wp_nxt  = buf_wp_r;
    buf_rp_nxt  = buf_rp_r;
    push_ready  = (buf_cnt_r != 2'h2);
    pop_valid   = (buf_cnt_r != 2'h0);
    if (push_valid && push_ready) begin
      buf_q_nxt[buf_wp_r] = push_data;
      buf_wp_nxt          = ~buf_wp_r;
    end
    if (pop_valid && pop_ready) begin
      buf_rp_nxt = ~buf_rp_r;
    end
    buf_cnt_nxt = buf_cnt_r + 2'((push_valid && push_ready) ? 1 : 0) - 2'((pop_valid && pop_ready) ? 1 : 0);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      buf_wp_r  <= 1'b0;
      buf_rp_r  <= 1'b0;
      buf_cnt_r <= 2'h0;
    end else if (i_ce) begin
      buf_q_r   <= buf_q_nxt;
      buf_wp_r  <= buf_wp_nxt;
      buf_rp_r  <= buf_rp_nxt;
      buf_cnt_r <= buf_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output registers, bus enable and echo clocks
  logic [DW-1:0] dq_r;
  logic [DW-1:0] dq_nxt;
  logic          oe_n_r;
  logic          oe_n_nxt;
  logic          echo_t_r;
  logic          echo_t_nxt;
  logic          echo_c_r;
  logic          echo_c_nxt;

  // a burst starts on a true edge only; the complement edge may only continue one
  always_comb begin
    dq_nxt     = dq_r;
    oe_n_nxt   = oe_n_r;
    pop_ready  = 1'b0;
    echo_t_nxt = out_t_lvl;
    echo_c_nxt = out_c_lvl;
    if (out_t_rise) begin
      if (pop_valid) begin
        pop_ready = 1'b1;
        dq_nxt    = buf_q_r[buf_rp_r];
        oe_n_nxt  = 1'b0;
      end else begin
        oe_n_nxt  = 1'b1;
      end
    end else if (out_c_rise && !oe_n_r && pop_valid) begin
      pop_ready = 1'b1;
      dq_nxt    = buf_q_r[buf_rp_r];
    end
  end

  // echo and data flip in the same cycle so they stay aligned
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dq_r     <= '0;
      oe_n_r   <= sram_port_pkg::OE_N_RST;
      echo_t_r <= 1'b0;
      echo_c_r <= 1'b0;
    end else if (i_ce) begin
      dq_r     <= dq_nxt;
      oe_n_r   <= oe_n_nxt;
      echo_t_r <= echo_t_nxt;
      echo_c_r <= echo_c_nxt;
    end
  end

  assign o_dq         = dq_r;
  assign o_dq_oe_n    = oe_n_r;
  assign o_echo_clk   = echo_t_r;
  assign o_echo_clk_n = echo_c_r;

endmodule // ddr2_burst2_sram_port

// ==== dv/ddr2_burst2_sram_port_checker.sv ====
module sram_port_checker #(
  parameter int unsigned DW = 18,
  parameter int unsigned AW = 8
) (
  input wire logic          i_core_clk,
  input wire logic          i_rst,
  input wire logic          i_ce,
  input wire logic          i_k,
  input wire logic          i_k_n,
  input wire logic          i_c,
  input wire logic          i_c_n,
  input wire logic          i_single_clk,
  input wire logic          i_load_strobe_n,
  input wire logic          i_rw,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_dq,
  input wire logic [DW-1:0] o_dq,
  input wire logic          o_dq_oe_n,
  input wire logic          o_echo_clk,
  input wire logic          o_echo_clk_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // a synchronous reset must leave the bus released and the echo pair low
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |=>
    o_dq_oe_n && !o_echo_clk && !o_echo_clk_n && o_dq == '0)
    else $error("outputs not quiet under reset");
  // read words move only together with an echo clock edge
  echo_align_a: assert property (!$stable(o_dq) |-> $changed(o_echo_clk) || $changed(o_echo_clk_n))
    else $error("read data moved without echo edge");
  burst_start_a: assert property ($fell(o_dq_oe_n) |-> $rose(o_echo_clk))
    else $error("bus taken off a true output rise");
  burst_end_a: assert property ($rose(o_dq_oe_n) |-> $rose(o_echo_clk))
    else $error("bus released off a true output rise");
  // a burst keeps the bus for both words, so at least one half period
  burst_hold_a: assert property ($fell(o_dq_oe_n) |=> !o_dq_oe_n [*8])
    else $error("burst cut short");
  echo_pair_a: assert property ($rose(o_echo_clk) |-> !o_echo_clk_n)
    else $error("echo pair not complementary");
  read_launch_a: assert property ($rose(i_k) && !i_load_strobe_n && i_rw |-> ##[3:40] !o_dq_oe_n)
    else $error("read never launched");
  write_quiet_a: assert property ($rose(i_k) && !i_load_strobe_n && !i_rw |-> ##8 o_dq_oe_n [*8])
    else $error("bus driven during write");
  // a low clock enable must hold every output where it stands
  freeze_hold_a: assert property (!i_ce |=>
    $stable(o_dq) && $stable(o_dq_oe_n) && $stable(o_echo_clk) && $stable(o_echo_clk_n))
    else $error("outputs moved while frozen");

  cover property ($fell(o_dq_oe_n));
  cover property (!i_ce);
  cover property ($fell(i_rst));
  cover property (i_single_clk && $fell(o_dq_oe_n));
  cover property ($rose(i_k) && !i_load_strobe_n && !i_rw);
endmodule // sram_port_checker

bind ddr2_burst2_sram_port sram_port_checker #(.DW(DW), .AW(AW)) i_checker (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_k(i_k), .i_k_n(i_k_n), .i_c(i_c), .i_c_n(i_c_n),
  .i_single_clk(i_single_clk), .i_load_strobe_n(i_load_strobe_n), .i_rw(i_rw), .i_addr(i_addr),
  .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_echo_clk(o_echo_clk), .o_echo_clk_n(o_echo_clk_n)
);

// ==== dv/mem_ctrl_model.sv ====
module mem_ctrl_model #(
  parameter int DW = 18,
  parameter int AW = 4
) (
  input  wire logic          i_core_clk,
  input  wire logic [DW-1:0] i_q,
  input  wire logic          i_q_oe_n,
  input  wire logic          i_echo,
  input  wire logic          i_echo_n,
  output logic               o_k,
  output logic               o_k_n,
  output logic               o_c,
  output logic               o_c_n,
  output logic               o_ld_n,
  output logic               o_rw,
  output logic [AW-1:0]      o_addr,
  output logic [DW-1:0]      o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]    cnt = 4'h0;
  logic [3:0]    cs;
  logic          drv = 1'b0;
  logic          pe = 1'b0;
  logic          pen = 1'b0;
  logic [DW-1:0] wd = '0;
  logic [DW-1:0] last = '0;
  logic [DW-1:0] rd0 = '0;
  logic [DW-1:0] rd1 = '0;
  int unsigned   nrd = 0;

  initial begin
    o_ld_n = 1'b1;
    o_rw = 1'b1;
    o_addr = '0;
  end
  // free-running pairs, 160 ns; output pair a quarter period ahead of the input pair
  always @(negedge i_core_clk) cnt <= cnt + 4'h1;
  assign cs = cnt + 4'h4;
  assign o_k = ~cnt[3];
  assign o_k_n = cnt[3];
  assign o_c = ~cs[3];
  assign o_c_n = cs[3];
  // released bus shows the inverse of its last value, never a stale copy
  assign o_bus = !i_q_oe_n ? i_q : drv ? wd : ~last;
  always @(posedge i_core_clk) begin
    if (!i_q_oe_n) last <= i_q;
    else if (drv) last <= wd;
  end
  // capture read words on the echo pair, only while the device drives
  always @(posedge i_core_clk) begin
    pe <= i_echo;
    pen <= i_echo_n;
    if (i_echo && !pe && !i_q_oe_n) rd0 <= i_q;
    if (i_echo_n && !pen && !i_q_oe_n) begin
      rd1 <= i_q;
      nrd <= nrd + 1;
    end
  end

  task automatic at(input logic [3:0] n);
    do @(negedge i_core_clk); while (cnt != n);
  endtask

  // one address per two k rises; strobe and select ride with the address
  task automatic xfer(input logic ld_n, input logic rw, input logic [AW-1:0] a, input logic [DW-1:0] w0,
                      input logic [DW-1:0] w1, output logic [DW-1:0] q0, output logic [DW-1:0] q1);
    int unsigned n;
    n = nrd;
    at(4'h7);
    o_ld_n <= ld_n;
    o_rw <= rw;
    o_addr <= a;
    at(4'h3);
    o_ld_n <= 1'b1;
    if (!rw) begin
      at(4'h7);
      wd <= w0;
      drv <= 1'b1;
      at(4'h3);
      wd <= w1;
      at(4'hB);
      drv <= 1'b0;
    end else begin
      for (int i = 0; i < 100 && nrd == n; i++) @(posedge i_core_clk);
      // hand back off the sampling edge so the next stimulus never races it
      @(negedge i_core_clk);
    end
    q0 = rd0;
    q1 = rd1;
  endtask
endmodule // mem_ctrl_model

// ==== dv/ddr2_burst2_sram_port_tb_top.sv ====
module ddr2_burst2_sram_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DW = 18;
  localparam int AW = 4;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          single = 1'b0;
  logic          ce = 1'b1;
  logic          k, k_n, c, c_n, ld_n, rw, oe_n, ec, ec_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] bus, q;
  logic [DW-1:0] ref_mem [2**AW];
  int unsigned   errors = 0;
  int unsigned   samples_checked = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  ddr2_burst2_sram_port #(.DW(DW), .AW(AW)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_k(k), .i_k_n(k_n), .i_c(c), .i_c_n(c_n),
    .i_single_clk(single), .i_load_strobe_n(ld_n), .i_rw(rw), .i_addr(addr), .i_dq(bus),
    .o_dq(q), .o_dq_oe_n(oe_n), .o_echo_clk(ec), .o_echo_clk_n(ec_n)
  );
  mem_ctrl_model #(.DW(DW), .AW(AW)) i_ctrl (
    .i_core_clk(clk), .i_q(q), .i_q_oe_n(oe_n), .i_echo(ec), .i_echo_n(ec_n), .o_k(k), .o_k_n(k_n),
    .o_c(c), .o_c_n(c_n), .o_ld_n(ld_n), .o_rw(rw), .o_addr(addr), .o_bus(bus)
  );

  // wide organisation: the burst counter starts at the address lsb
  function automatic logic [AW-1:0] idx(input logic [AW-1:0] a, input logic b);
    return {a[AW-1:1], b};
  endfunction

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // random write then read of the same pair, entered from either end
  initial begin
    logic [AW-1:0] a;
    logic [DW-1:0] w0, w1, q0, q1;
    void'($urandom(32'h0A79671A));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int n = 0; n < 24; n++) begin
      a = AW'($urandom);
      w0 = DW'($urandom);
      w1 = DW'($urandom);
      if (n == 16) single = 1'b1;
      // second reset in mid-run; the array has no reset and keeps its pairs
      if (n == 20) begin
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
      end
      i_ctrl.xfer(1'b0, 1'b0, a, w0, w1, q0, q1);
      ref_mem[idx(a, a[0])] = w0;
      ref_mem[idx(a, ~a[0])] = w1;
      // a high strobe must leave the stored pair alone
      if (n == 8) i_ctrl.xfer(1'b1, 1'b0, a, ~w0, ~w1, q0, q1);
      a[0] = n[0];
      i_ctrl.xfer(1'b0, 1'b1, a, w0, w1, q0, q1);
      check(q0, ref_mem[idx(a, a[0])]);
      check(q1, ref_mem[idx(a, ~a[0])]);
      // freeze between transfers; the checker sees the outputs hold
      if (n == 4) begin
        ce = 1'b0;
        repeat (12) @(negedge clk);
        ce = 1'b1;
      end
    end
    complete_run();
  end

  // about eight times the expected run length
  initial begin
    #200us;
    errors++;
    complete_run();
  end
endmodule // ddr2_burst2_sram_port_tb_top
